// >>> hw/wrap_irq_pkg.sv
// Constants shared by the timer interrupt and flag logic.
// Assumes a 50 MHz peripheral clock and three counting channels.
package wrap_irq_pkg;
  localparam int          NUM_CH        = 3;
  localparam int          CNT_W         = 32;
  localparam int          CODE_W        = 12;
  localparam logic [31:0] CNT_RESET     = 32'hffffffff;
  localparam logic [31:0] CNT_WRAP_FROM = 32'h00000000;
  localparam logic [31:0] CAP_RESET     = 32'h00000000;
  // Source codes are arbitrary values; the interrupt controller maps them
  localparam logic [11:0] CODE_NONE     = 12'h000;
  localparam logic [11:0] CODE_WRAP_CH0 = 12'h400;
  localparam logic [11:0] CODE_WRAP_CH1 = 12'h420;
  localparam logic [11:0] CODE_WRAP_CH2 = 12'h440;
  localparam logic [11:0] CODE_CAP_CH2  = 12'h460;
  // Capture edge select encodings
  localparam logic [1:0]  EDGE_RISE     = 2'h0;
  localparam logic [1:0]  EDGE_FALL     = 2'h1;
endpackage

// >>> hw/pin_edge_detect.sv
// Synchronises the external timer pin and flags the selected edge.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/10ps
module pin_edge_detect
  import wrap_irq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       pinIn,
  input  wire logic [1:0] edgeSel,
  output logic            edgeHit
);
  logic sync1_q, sync2_q, prev_q, hit_q;
  logic hit_d;

  always_comb begin
    unique case (edgeSel)
      EDGE_RISE: hit_d = sync2_q & ~prev_q;
      EDGE_FALL: hit_d = ~sync2_q & prev_q;
      default:   hit_d = sync2_q ^ prev_q;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      hit_q   <= 1'b0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      hit_q   <= hit_d;
    end
  end

  assign edgeHit = hit_q;
endmodule // pin_edge_detect

// >>> hw/timer_underflow_interrupt_logic.sv
// Three-channel down counters with wrap flags, interrupts and capture.
// Assumes count ticks come from a same-clock prescaler; pin is async.
//
// Contract
// - Only two source kinds: counter wrap, and capture on channel 2.
// - Each channel drives its own wrap interrupt request line.
// - Wrap flag sets when a counter goes from zero to its reload constant.
// - Wrap flag clears only when software writes one to its clear bit.
// - A request is raised only in the cycle after its flag and enable are both one.
// - Each source places its own code in the source code register.
// - Priority: wrap ch0, wrap ch1, wrap ch2, then capture ch2.
// - A read coinciding with a decrement returns the pre-decrement value.
// - On wrap the counter reloads from the reload constant register.
// - A pin capture edge copies channel 2 count into the capture register.
`timescale 1ns/10ps
module timer_underflow_interrupt_logic
  import wrap_irq_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic [NUM_CH-1:0]      channel_run_bits,
  input  wire logic [NUM_CH-1:0]      countTick,
  input  wire logic [NUM_CH-1:0]      wrap_irq_enable,
  input  wire logic                   captureEnable,
  input  wire logic                   captureIrqEnable,
  input  wire logic [1:0]             captureEdgeSel,
  input  wire logic                   external_timer_pin,
  input  wire logic [NUM_CH-1:0]      wrapFlagClr,
  input  wire logic                   captureFlagClr,
  input  wire logic [NUM_CH-1:0]      counterWrite,
  input  wire logic [NUM_CH-1:0]      reloadWrite,
  input  wire logic [CNT_W-1:0]       writeData,
  input  wire logic                   readStrobe,
  input  wire logic [1:0]             readSel,
  output logic [CNT_W-1:0]            readData,
  output logic [NUM_CH-1:0]           wrap_flag,
  output logic                        captureFlag,
  output logic                        counter_wrap_irq_ch0,
  output logic                        counter_wrap_irq_ch1,
  output logic                        counter_wrap_irq_ch2,
  output logic                        capture_irq_ch2,
  output logic [CNT_W-1:0]            capture_value_reg,
  output logic [CODE_W-1:0]           exception_source_code_reg
);
  logic [CNT_W-1:0]  down_counter_q  [NUM_CH];
  logic [CNT_W-1:0]  down_counter_d  [NUM_CH];
  logic [CNT_W-1:0]  reload_constant_reg_q [NUM_CH];
  logic [CNT_W-1:0]  reload_constant_reg_d [NUM_CH];
  // Wrap flags, one bit per channel
  logic [NUM_CH-1:0] wrapFlag_q;
  logic [NUM_CH-1:0] wrapFlag_d;
  logic [NUM_CH-1:0] wrapEvent;
  // Capture flag and captured count of channel 2
  logic              capFlag_q;
  logic              capFlag_d;
  logic [CNT_W-1:0]  capVal_q;
  logic [CNT_W-1:0]  capVal_d;
  // Read buffer holds the whole word, so halves never tear
  logic [CNT_W-1:0]  readData_q;
  logic [CNT_W-1:0]  readData_d;
  // Requests: bits 0..2 wrap per channel, bit 3 capture
  logic [3:0]        irq_q;
  logic [3:0]        irq_d;
  logic [CODE_W-1:0] code_q;
  logic [CODE_W-1:0] code_d;
  logic              pinEdge;
  logic              capEvent;

  pin_edge_detect u_edge (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pinIn   (external_timer_pin),
    .edgeSel (captureEdgeSel),
    .edgeHit (pinEdge)
  );

  assign capEvent = pinEdge & captureEnable;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic tick;
      assign tick = channel_run_bits[g] & countTick[g];
      assign wrapEvent[g] = tick & (down_counter_q[g] == CNT_WRAP_FROM);

      always_comb begin
        down_counter_d[g] = down_counter_q[g];
        reload_constant_reg_d[g] = reload_constant_reg_q[g];
        // Writes are not synchronised with counting; stopped channel assumed
        if (counterWrite[g]) begin
          down_counter_d[g] = writeData;
        end else if (wrapEvent[g]) begin
          down_counter_d[g] = reload_constant_reg_q[g];
        end else if (tick) begin
          down_counter_d[g] = down_counter_q[g] - 32'h00000001;
        end
        if (reloadWrite[g]) begin
          reload_constant_reg_d[g] = writeData;
        end
        // Set beats a coinciding software clear
        wrapFlag_d[g] = wrapEvent[g] | (wrapFlag_q[g] & ~wrapFlagClr[g]);
      end

      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          down_counter_q[g]        <= CNT_RESET;
          reload_constant_reg_q[g] <= CNT_RESET;
          wrapFlag_q[g]            <= 1'b0;
        end else begin
          down_counter_q[g]        <= down_counter_d[g];
          reload_constant_reg_q[g] <= reload_constant_reg_d[g];
          wrapFlag_q[g]            <= wrapFlag_d[g];
        end
      end
    end
  endgenerate

  always_comb begin
    capFlag_d = capEvent | (capFlag_q & ~captureFlagClr);
    capVal_d  = capEvent ? down_counter_q[2] : capVal_q;
  end

  // Read samples the settled count, so a same-cycle decrement is not seen
  always_comb begin
    readData_d = readData_q;
    if (readStrobe) begin
      unique case (readSel)
        2'h0:    readData_d = down_counter_q[0];
        2'h1:    readData_d = down_counter_q[1];
        2'h2:    readData_d = down_counter_q[2];
        default: readData_d = capVal_q;
      endcase
    end
  end

  always_comb begin
    irq_d[0] = wrapFlag_q[0] & wrap_irq_enable[0];
    irq_d[1] = wrapFlag_q[1] & wrap_irq_enable[1];
    irq_d[2] = wrapFlag_q[2] & wrap_irq_enable[2];
    irq_d[3] = capFlag_q & captureIrqEnable;
    if (irq_d[0]) begin
      code_d = CODE_WRAP_CH0;
    end else if (irq_d[1]) begin
      code_d = CODE_WRAP_CH1;
    end else if (irq_d[2]) begin
      code_d = CODE_WRAP_CH2;
    end else if (irq_d[3]) begin
      code_d = CODE_CAP_CH2;
    end else begin
      code_d = CODE_NONE;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      capFlag_q  <= 1'b0;
      capVal_q   <= CAP_RESET;
      readData_q <= CAP_RESET;
      irq_q      <= 4'h0;
      code_q     <= CODE_NONE;
    end else begin
      capFlag_q  <= capFlag_d;
      capVal_q   <= capVal_d;
      readData_q <= readData_d;
      irq_q      <= irq_d;
      code_q     <= code_d;
    end
  end

  assign readData                  = readData_q;
  assign wrap_flag                 = wrapFlag_q;
  assign captureFlag               = capFlag_q;
  assign counter_wrap_irq_ch0      = irq_q[0];
  assign counter_wrap_irq_ch1      = irq_q[1];
  assign counter_wrap_irq_ch2      = irq_q[2];
  assign capture_irq_ch2           = irq_q[3];
  assign capture_value_reg         = capVal_q;
  assign exception_source_code_reg = code_q;
endmodule // timer_underflow_interrupt_logic

// >>> verif/wrap_irq_assertions.sv
// Checks on wrap flags, request lines and source codes.
// Bound to the timer top module; sees its ports only.
`timescale 1ns/10ps
module wrap_irq_assertions
  import wrap_irq_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic [NUM_CH-1:0] wrap_irq_enable,
  input wire logic              captureIrqEnable,
  input wire logic [NUM_CH-1:0] wrapFlagClr,
  input wire logic [NUM_CH-1:0] wrap_flag,
  input wire logic              captureFlag,
  input wire logic              counter_wrap_irq_ch0,
  input wire logic              counter_wrap_irq_ch1,
  input wire logic              counter_wrap_irq_ch2,
  input wire logic              capture_irq_ch2,
  input wire logic [CODE_W-1:0] exception_source_code_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_pend0;
    wrap_flag[0] && wrap_irq_enable[0];
  endsequence
  sequence s_none;
    !counter_wrap_irq_ch0 && !counter_wrap_irq_ch1 && !counter_wrap_irq_ch2;
  endsequence
  a_irq0_raise: assert property (s_pend0 |=> counter_wrap_irq_ch0)
    else $error("ch0 request missing");
  a_irq0_quiet: assert property (!(wrap_flag[0] && wrap_irq_enable[0])
    |=> !counter_wrap_irq_ch0) else $error("ch0 request spurious");
  a_irq1_follow: assert property (counter_wrap_irq_ch1 ==
    $past(wrap_flag[1] && wrap_irq_enable[1])) else $error("ch1 request");
  a_irq2_follow: assert property (counter_wrap_irq_ch2 ==
    $past(wrap_flag[2] && wrap_irq_enable[2])) else $error("ch2 request");
  a_cap_follow: assert property (capture_irq_ch2 ==
    $past(captureFlag && captureIrqEnable)) else $error("capture request");
  a_code_ch0: assert property (counter_wrap_irq_ch0 |->
    exception_source_code_reg == CODE_WRAP_CH0) else $error("code ch0");
  a_code_ch1: assert property (!counter_wrap_irq_ch0 && counter_wrap_irq_ch1
    |-> exception_source_code_reg == CODE_WRAP_CH1) else $error("code ch1");
  a_code_cap: assert property (s_none and capture_irq_ch2
    |-> exception_source_code_reg == CODE_CAP_CH2) else $error("code cap");
  a_code_none: assert property (s_none and !capture_irq_ch2
    |-> exception_source_code_reg == CODE_NONE) else $error("code none");
  a_flag_keep: assert property (wrap_flag[1] && !wrapFlagClr[1]
    |=> wrap_flag[1]) else $error("flag lost");
endmodule // wrap_irq_assertions
bind timer_underflow_interrupt_logic wrap_irq_assertions u_chk (.*);

// >>> verif/cpu_service_model.sv
// Processor side: services wrap requests by writing one to the flag's clear bit.
// Retries while the request stays up, as a slow count clock needs.
`timescale 1ns/10ps
module cpu_service_model
  import wrap_irq_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              serviceOn,
  input  wire logic              slowAns,
  input  wire logic [NUM_CH-1:0] irqLines,
  output logic      [NUM_CH-1:0] clrPulse
);
  initial clrPulse = 3'h0;
  always @(posedge sys_clk) begin
    if (serviceOn && irqLines != 3'h0) begin
      repeat (slowAns ? 5 : 0) @(posedge sys_clk);
      #1 clrPulse = irqLines;
      @(posedge sys_clk) #1 clrPulse = 3'h0;
      repeat (2) @(posedge sys_clk);
    end
  end
endmodule // cpu_service_model

// >>> verif/timer_underflow_interrupt_logic_tb.sv
// Self-checking bench for the timer wrap, capture and code logic.
// Drives every input 1 ns after the rising edge of sys_clk.
`timescale 1ns/10ps
module timer_underflow_interrupt_logic_tb;
  import wrap_irq_pkg::*;
  logic sys_clk, reset, captureEnable, captureIrqEnable, serviceOn, slowAns;
  logic external_timer_pin, captureFlagClr, readStrobe, captureFlag;
  logic counter_wrap_irq_ch0, counter_wrap_irq_ch1;
  logic counter_wrap_irq_ch2, capture_irq_ch2;
  logic [1:0] captureEdgeSel, readSel;
  logic [2:0] channel_run_bits, countTick, wrap_irq_enable, wrapFlagClr;
  logic [2:0] counterWrite, reloadWrite, wrap_flag;
  logic [31:0] writeData, readData, capture_value_reg, rl[3];
  logic [11:0] exception_source_code_reg;
  int n_mismatch, n_checks;
  timer_underflow_interrupt_logic uut (.*);
  cpu_service_model cpu (.sys_clk(sys_clk), .serviceOn(serviceOn),
    .slowAns(slowAns), .clrPulse(wrapFlagClr), .irqLines({
    counter_wrap_irq_ch2, counter_wrap_irq_ch1, counter_wrap_irq_ch0}));
  function automatic logic [11:0] code_of(logic [2:0] p, logic c);
    return p[0] ? CODE_WRAP_CH0 : p[1] ? CODE_WRAP_CH1 :
      p[2] ? CODE_WRAP_CH2 : c ? CODE_CAP_CH2 : CODE_NONE;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #20000 n_mismatch++;
    final_report();
  end
  initial begin
    {reset, captureEnable, captureIrqEnable, serviceOn, slowAns} = 5'h10;
    {external_timer_pin, captureFlagClr, readStrobe, readSel} = 5'h0;
    {captureEdgeSel, channel_run_bits, countTick} = 8'h0;
    {counterWrite, reloadWrite, writeData} = 38'h0;
    wrap_irq_enable = 3'h7;
    void'($urandom(60843));
    cyc(6);
    reset = 0;
    for (int c = 0; c < 3; c++) begin
      rl[c] = $urandom | 32'h10;
      writeData = rl[c];
      reloadWrite = 3'h1 << c;
      cyc(1);
      reloadWrite = 3'h0;
      writeData = CNT_WRAP_FROM;
      counterWrite = 3'h1 << c;
      cyc(1);
      counterWrite = 3'h0;
      channel_run_bits = 3'h1 << c;
      countTick = 3'h1 << c;
      cyc(1);
      chk(wrap_flag[c], 1'b1);
      readSel = 2'(c);
      readStrobe = 1;
      cyc(1);
      chk(readData, rl[c]);
      cyc(1);
      chk(readData, rl[c] - 32'h1);
      countTick = 3'h0;
      readStrobe = 0;
      channel_run_bits = 3'h0;
    end
    for (int i = 0; i < 10; i++) begin
      wrap_irq_enable = (i == 0) ? 3'h6 : 3'($urandom);
      cyc(2);
      chk(exception_source_code_reg, code_of(wrap_irq_enable, 0));
      chk(counter_wrap_irq_ch1, wrap_irq_enable[1]);
    end
    wrap_irq_enable = 3'h0;
    {captureEnable, captureIrqEnable, captureEdgeSel} = {2'h3, EDGE_RISE};
    external_timer_pin = 1;
    cyc(7);
    chk(capture_value_reg, rl[2] - 32'h2);
    chk(exception_source_code_reg, CODE_CAP_CH2);
    captureFlagClr = 1;
    cyc(1);
    captureFlagClr = 0;
    cyc(2);
    chk(exception_source_code_reg, CODE_NONE);
    {wrap_irq_enable, serviceOn, slowAns} = {3'h7, 1'b1, 1'($urandom)};
    cyc(40);
    chk(wrap_flag, 3'h0);
    final_report();
  end
endmodule // timer_underflow_interrupt_logic_tb
